// ==== bench/dcr_regs_properties.sv ====
`include "dcr_consts.svh"

// ==========================================================
// port-level checks of the offset bank
module dcr_regs_properties
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input wire logic               clk,
    input wire logic               arst_n,
    // register port
    input wire logic [ADDR_W-1:0]  reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    // code path and modes
    input wire logic               code_valid,
    input wire dcr_pkg::dcr_code_t code_in,
    input wire logic               corr_valid,
    input wire dcr_pkg::dcr_code_t corr_code,
    input wire logic               atten_en,
    input wire logic               hs_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wr_ctrl = reg_wr && reg_addr == `DCR_OFS_DAC_CTRL;
    // control, status and offset registers have reserved upper bits; only the offsets are checked here; the lock word is full width
    wire rd_offset = reg_rd && (reg_addr == `DCR_OFS_ATTEN_LP || reg_addr == `DCR_OFS_NOATTEN_LP
                     || reg_addr == `DCR_OFS_ATTEN_HS || reg_addr == `DCR_OFS_NOATTEN_HS);

    property p_rd_upper;
        $past(rd_offset) |-> reg_rdata[31:12] == 20'h00000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    property p_valid;
        code_valid |=> corr_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("corr_valid missing");
    property p_novalid;
        !code_valid |=> !corr_valid;
    endproperty
    a_novalid: assert property (p_novalid) else $error("stray corr_valid");
    property p_hold;
        !corr_valid |-> $stable(corr_code);
    endproperty
    a_hold: assert property (p_hold) else $error("corr_code moved");
    property p_atten;
        wr_ctrl |=> atten_en == $past(reg_wdata[0]);
    endproperty
    a_atten: assert property (p_atten) else $error("atten_en wrong");
    property p_hs;
        wr_ctrl |=> hs_mode == $past(reg_wdata[1]);
    endproperty
    a_hs: assert property (p_hs) else $error("hs_mode wrong");
    property p_atten_keep;
        !wr_ctrl |=> $stable(atten_en);
    endproperty
    a_atten_keep: assert property (p_atten_keep) else $error("atten_en moved");
    property p_readback;
        reg_wr && reg_addr == `DCR_OFS_NOATTEN_LP ##1 reg_rd && reg_addr == `DCR_OFS_NOATTEN_LP
        |=> reg_rdata == {20'h00000, $past(reg_wdata[11:0], 2)};
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
    property p_refuse;
        reg_wr && reg_addr == `DCR_OFS_CAL_LOCK && reg_wdata != `DCR_UNLOCK_KEY
        ##1 reg_wr && reg_addr == `DCR_OFS_NOATTEN_HS ##1 reg_rd && reg_addr == `DCR_OFS_STATUS
        |=> reg_rdata[1:0] == 2'b10;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal not flagged");
    property p_status;
        reg_rd && reg_addr == `DCR_OFS_STATUS
        |=> reg_rdata[5:2] == {$past(hs_mode), $past(atten_en), $past(hs_mode), $past(atten_en)};
    endproperty
    a_status: assert property (p_status) else $error("mode status wrong");
endmodule

bind dcr_regs dcr_regs_properties #(.ADDR_W(ADDR_W)) u_props
(
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_valid(code_valid),
    .code_in(code_in), .corr_valid(corr_valid), .corr_code(corr_code),
    .atten_en(atten_en), .hs_mode(hs_mode)
);

// ==== bench/tb.sv ====
`include "dcr_consts.svh"
`define CHK(got, exp) \
    begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end

// ==========================================================
// self-checking bench for the offset bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dcr_pkg::*;
    logic        clk, arst_n, reg_wr, reg_rd, code_valid, corr_valid, atten_en, hs_mode;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    dcr_code_t   code_in, corr_code;
    int          errors, total_checks;
    logic [15:0] sel_addr [4] = '{`DCR_OFS_NOATTEN_LP, `DCR_OFS_ATTEN_LP,
                                  `DCR_OFS_NOATTEN_HS, `DCR_OFS_ATTEN_HS};
    logic [11:0] corner [5] = '{12'h7FF, 12'h800, 12'h000, 12'h001, 12'hFFF};

    dcr_regs uut
    (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_valid(code_valid),
        .code_in(code_in), .corr_valid(corr_valid), .corr_code(corr_code),
        .atten_en(atten_en), .hs_mode(hs_mode)
    );

    // strobe stays up until the next task's edge, so accesses run back to back
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // floor of the half-step sum, clamped to the code range
    function automatic dcr_code_t exp_corr(dcr_code_t c, logic [11:0] off);
        int v;
        v = (2 * int'(c) + int'($signed(off))) >>> 1;
        return (v < 0) ? 12'h000 : (v > 4095) ? 12'hFFF : 12'(v);
    endfunction
    task automatic apply(input dcr_code_t c, input logic [11:0] off);
        @(posedge clk);
        reg_wr <= 1'b0;
        code_valid <= 1'b1;
        code_in <= c;
        @(posedge clk);
        code_valid <= 1'b0;
        #1;
        `CHK(corr_valid, 1'b1)
        `CHK(corr_code, exp_corr(c, off))
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // clock of 100 ns
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial
    begin
        {arst_n, reg_wr, reg_rd, code_valid} = 4'h0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0;
        code_in = 12'h000;
        errors = 0;
        total_checks = 0;
        void'($urandom(94));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        foreach (sel_addr[i])
        begin
            rd(sel_addr[i], d);
            `CHK(d, 32'h0)
        end
        rd(`DCR_OFS_CAL_LOCK, d);
        `CHK(d, `DCR_RST_LOCK)
        rd(16'h0100, d);
        `CHK(d, 32'h0)
        wr(`DCR_OFS_NOATTEN_LP, 32'hFFFFFFFF);
        rd(`DCR_OFS_NOATTEN_LP, d);
        `CHK(d, 32'h00000FFF)
        wr(`DCR_OFS_ATTEN_HS, 32'h00000123);
        rd(`DCR_OFS_ATTEN_HS, d);
        `CHK(d, 32'h0)
        wr(`DCR_OFS_STATUS, 32'h2);
        wr(`DCR_OFS_CAL_LOCK, `DCR_UNLOCK_KEY);
        rd(`DCR_OFS_STATUS, d);
        `CHK(d[1:0], 2'b01)
        wr(`DCR_OFS_NOATTEN_HS, 32'h00000456);
        wr(`DCR_OFS_CAL_LOCK, 32'h0);
        wr(`DCR_OFS_NOATTEN_HS, 32'h00000789);
        rd(`DCR_OFS_STATUS, d);
        `CHK(d[1:0], 2'b10)
        rd(`DCR_OFS_NOATTEN_HS, d);
        `CHK(d, 32'h00000456)
        wr(`DCR_OFS_CAL_LOCK, `DCR_UNLOCK_KEY);
        // every mode, every corner offset, others random to prove the selection
        for (int m = 0; m < 4; m++)
        begin
            wr(`DCR_OFS_DAC_CTRL, 32'(m));
            rd(`DCR_OFS_STATUS, d);
            `CHK(d[5:2], {2'(m), 2'(m)})
            `CHK({hs_mode, atten_en}, 2'(m))
            foreach (corner[k])
            begin
                foreach (sel_addr[j])
                    wr(sel_addr[j], (j == m) ? 32'(corner[k]) : $urandom);
                apply(12'h000, corner[k]);
                apply(12'hFFF, corner[k]);
                apply(12'($urandom_range(0, 4095)), corner[k]);
            end
        end
        complete_run();
    end
endmodule

// ==== rtl/dcr_consts.svh ====
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define DCR_OFS_DAC_CTRL        16'h2010
`define DCR_OFS_CAL_LOCK        16'h2230
`define DCR_OFS_ATTEN_LP        16'h2264
`define DCR_OFS_NOATTEN_LP      16'h2268
`define DCR_OFS_ATTEN_HS        16'h22B8
`define DCR_OFS_NOATTEN_HS      16'h22BC
`define DCR_OFS_STATUS          16'h2014

// ==========================================================
// field positions
`define DCR_OFFSET_MSB          11
`define DCR_CTRL_ATTEN_BIT      0
`define DCR_CTRL_HSMODE_BIT     1
`define DCR_STAT_UNLOCK_BIT     0
`define DCR_STAT_REJECT_BIT     1
`define DCR_STAT_ATTEN_BIT      2
`define DCR_STAT_HSMODE_BIT     3
`define DCR_STAT_SEL_LSB        4

// ==========================================================
// reset values and keys
`define DCR_RST_OFFSET          12'h000
`define DCR_RST_LOCK            32'hDE87A5A0
`define DCR_UNLOCK_KEY          32'hDE87A5AF
`define DCR_RST_CTRL            2'h0
`define DCR_DAC_CODE_MAX        12'hFFF
`define DCR_DAC_CODE_MIN        12'h000

`endif

// ==== rtl/dcr_corr_apply.sv ====
`include "dcr_consts.svh"

module dcr_corr_apply
(
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // selected offset and raw code
    dcr_corr_if.datapath cif
);
    import dcr_pkg::*;

    logic signed [14:0] sum_half;
    logic        [11:0] nxt_code;
    logic        [11:0] corr_code_ff;
    logic               corr_valid_ff;

    // ==========================================================
    // add offset in half-LSB units, then drop the half bit
    always_comb
    begin
        // code doubled so the offset lsb is half a dac lsb
        sum_half = $signed({2'b00, cif.code, 1'b0}) + 15'(cif.offset);
        // clamp rather than wrap: a wrapped code would jump full scale
        if (sum_half < 15'sd0)
        begin
            nxt_code = `DCR_DAC_CODE_MIN;
        end
        // top of range in half steps: full code plus the half that is dropped
        else if (sum_half > $signed({2'b00, `DCR_DAC_CODE_MAX, 1'b1}))
        begin
            nxt_code = `DCR_DAC_CODE_MAX;
        end
        else
        begin
            nxt_code = sum_half[12:1];
        end
    end

    // corrected code register, one cycle after the raw code
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            corr_code_ff  <= 12'h000;
            corr_valid_ff <= 1'b0;
        end
        else
        begin
            corr_valid_ff <= cif.code_valid;
            if (cif.code_valid)
            begin
                corr_code_ff <= nxt_code;
            end
        end
    end

    assign cif.corr_code  = corr_code_ff;
    assign cif.corr_valid = corr_valid_ff;
endmodule

// ==== rtl/dcr_corr_if.sv ====
interface dcr_corr_if;
    import dcr_pkg::*;
    // ==========================================================
    // selected offset handed to the correction datapath
    dcr_offset_t offset;
    logic        code_valid;
    dcr_code_t   code;
    dcr_code_t   corr_code;
    logic        corr_valid;

    modport regs
    (
        output offset,
        output code_valid,
        output code,
        input  corr_code,
        input  corr_valid
    );
    modport datapath
    (
        input  offset,
        input  code_valid,
        input  code,
        output corr_code,
        output corr_valid
    );
endinterface

// ==== rtl/dcr_pkg.sv ====
package dcr_pkg;
    // ==========================================================
    // types
    typedef logic [11:0]        dcr_code_t;
    typedef logic signed [11:0] dcr_offset_t;

    // which of the four offset registers is in use
    typedef enum logic [1:0]
    {
        DCR_SEL_NOATTEN_LP = 2'b00,
        DCR_SEL_ATTEN_LP   = 2'b01,
        DCR_SEL_NOATTEN_HS = 2'b10,
        DCR_SEL_ATTEN_HS   = 2'b11
    } dcr_sel_t;
endpackage

// ==== rtl/dcr_regs.sv ====
// The implementer's own choice: the address-and-strobe port.
`include "dcr_consts.svh"

module dcr_regs
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output      logic [31:0]       reg_rdata,
    // dac code path
    input  wire logic              code_valid,
    input  wire dcr_pkg::dcr_code_t code_in,
    output      logic              corr_valid,
    output      dcr_pkg::dcr_code_t corr_code,
    // mode outputs to the analog side
    output      logic              atten_en,
    output      logic              hs_mode
);
    import dcr_pkg::*;

    // ==========================================================
    // register map, byte offsets on reg_addr
    //   all registers are 32 bits wide on the port
    //   0x2010  dac control, bits 1:0 read/write, rest read zero
    //           bit 0 attenuator on (gain 0.2); clear gives gain 1
    //           bit 1 high-speed mode; clear gives low-power mode
    //   0x2014  status, read only apart from the clear bit
    //           bit 0 key in place, protected offsets writable
    //           bit 1 protected write refused; write 1 to clear
    //           bit 2 attenuator on, copy of control bit 0
    //           bit 3 high-speed mode, copy of control bit 1
    //           bits 5:4 offset set in use, {mode, attenuator}
    //   0x2230  calibration lock word, all 32 bits read/write
    //   0x2264  offset, attenuator on, low-power mode
    //   0x2268  offset, attenuator off, low-power mode
    //   0x22B8  offset, attenuator on, high-speed mode, locked
    //   0x22BC  offset, attenuator off, high-speed mode, locked
    //   others  writes dropped, reads return zero

    // ==========================================================
    // offset format
    //   bits 11:0 two's complement, one step is half a dac lsb
    //   bits 31:12 not stored, so they read zero whatever is written
    //   reserved bits are ignored on write
    //   0x7FF most positive, half an lsb short of a quarter of full scale
    //   0x800 most negative, a quarter of full scale down
    //   0x001 and 0xFFF nudge by plus and minus half an lsb
    //   0x000 leaves the code alone, and is the value after reset

    // ==========================================================
    // lock behaviour
    //   the lock word resets to a value that is not the key, so the
    //   high-speed offsets start out locked after every reset
    //   writing the key opens them; any other value closes them
    //   the word reads back as written, so software sees the state
    //   a refused write leaves the offset untouched and raises the
    //   sticky status flag; a refusal in the cycle of a clear wins,
    //   so a refusal is never lost to a late clear
    //   the status clear is write-one; writing zero there does nothing
    //   limitation: the key is compared as one word, no byte lanes
    //   the low-power offsets are never locked, by design choice

    // ==========================================================
    // register port timing
    //   a write lands at the edge that samples the strobe
    //   read data stand only in the cycle after the strobe and are
    //   zero otherwise, so a stale word never lingers on the bus
    //   strobes may follow each other with no gap; nothing waits
    //   a read right after a write returns the new value, since the
    //   read mux looks at the flops the write has just loaded

    // ==========================================================
    // correction path
    //   the set in use follows control bits 1:0 as {mode, attenuator}
    //   a mode change takes effect on the next sampled code
    //   a new offset written during a run applies to the next sample
    //   the corrected code is registered one cycle after code_valid
    //   and holds until the next valid, so the dac sees no glitch
    //   the sum saturates at both ends instead of wrapping, which
    //   costs two compares but keeps the transfer monotonic
    //   the half step is dropped by rounding toward minus infinity
    //   no dithering of the dropped half step is attempted

    // ==========================================================
    // limits and trade-offs
    //   no byte enables: each write replaces the whole field
    //   status is built from live flops, not a snapshot, so two
    //   reads in a row may differ if a write lands between them
    //   an address width under 6 bits would fold offsets together
    //   the lock word has no effect on reads; every offset can be
    //   read back whether the bank is locked or not
    //   code_valid may stay high every cycle; each cycle is one
    //   sample and gives one corrected code
    //   mode outputs change at the write edge, ahead of the next code

    // ==========================================================
    // storage
    logic [11:0] off_atten_lp_ff;
    logic [11:0] off_noatten_lp_ff;
    logic [11:0] off_atten_hs_ff;
    logic [11:0] off_noatten_hs_ff;
    logic [31:0] lock_ff;
    logic [1:0]  ctrl_ff;
    logic        reject_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        unlocked;
    logic        wr_atten_hs;
    logic        wr_noatten_hs;
    logic        wr_status;
    dcr_sel_t    sel;
    logic [11:0] sel_offset;

    dcr_corr_if cif ();

    // ==========================================================
    // address decode for writes
    assign unlocked      = (lock_ff == `DCR_UNLOCK_KEY);
    assign wr_atten_hs   = reg_wr && (reg_addr == ADDR_W'(`DCR_OFS_ATTEN_HS));
    assign wr_noatten_hs = reg_wr && (reg_addr == ADDR_W'(`DCR_OFS_NOATTEN_HS));
    assign wr_status     = reg_wr && (reg_addr == ADDR_W'(`DCR_OFS_STATUS));

    // low-power offsets are never locked
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            off_atten_lp_ff   <= `DCR_RST_OFFSET;
            off_noatten_lp_ff <= `DCR_RST_OFFSET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_W'(`DCR_OFS_ATTEN_LP))
            begin
                off_atten_lp_ff <= reg_wdata[`DCR_OFFSET_MSB:0];
            end
            else if (reg_addr == ADDR_W'(`DCR_OFS_NOATTEN_LP))
            begin
                off_noatten_lp_ff <= reg_wdata[`DCR_OFFSET_MSB:0];
            end
        end
    end

    // high-speed offsets keep their value unless the key is in place
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            off_atten_hs_ff   <= `DCR_RST_OFFSET;
            off_noatten_hs_ff <= `DCR_RST_OFFSET;
        end
        else
        begin
            if (wr_atten_hs && unlocked)
            begin
                off_atten_hs_ff <= reg_wdata[`DCR_OFFSET_MSB:0];
            end
            if (wr_noatten_hs && unlocked)
            begin
                off_noatten_hs_ff <= reg_wdata[`DCR_OFFSET_MSB:0];
            end
        end
    end

    // lock word: any other value written locks again
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_ff <= `DCR_RST_LOCK;
        end
        else if (reg_wr && (reg_addr == ADDR_W'(`DCR_OFS_CAL_LOCK)))
        begin
            lock_ff <= reg_wdata;
        end
    end

    // dac control: attenuator and operating mode
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_ff <= `DCR_RST_CTRL;
        end
        else if (reg_wr && (reg_addr == ADDR_W'(`DCR_OFS_DAC_CTRL)))
        begin
            ctrl_ff[0] <= reg_wdata[`DCR_CTRL_ATTEN_BIT];
            ctrl_ff[1] <= reg_wdata[`DCR_CTRL_HSMODE_BIT];
        end
    end

    // sticky flag for a refused protected write; new refusal beats clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reject_ff <= 1'b0;
        end
        else if ((wr_atten_hs || wr_noatten_hs) && !unlocked)
        begin
            reject_ff <= 1'b1;
        end
        else if (wr_status && reg_wdata[`DCR_STAT_REJECT_BIT])
        begin
            reject_ff <= 1'b0;
        end
    end

    // ==========================================================
    // offset selection by mode and attenuator
    assign atten_en = ctrl_ff[0];
    assign hs_mode  = ctrl_ff[1];
    assign sel      = dcr_sel_t'({hs_mode, atten_en});

    always_comb
    begin
        case (sel)
            DCR_SEL_ATTEN_LP:   sel_offset = off_atten_lp_ff;
            DCR_SEL_NOATTEN_HS: sel_offset = off_noatten_hs_ff;
            DCR_SEL_ATTEN_HS:   sel_offset = off_atten_hs_ff;
            default:            sel_offset = off_noatten_lp_ff;
        endcase
    end

    assign cif.offset     = sel_offset;
    assign cif.code       = code_in;
    assign cif.code_valid = code_valid;
    assign corr_code      = cif.corr_code;
    assign corr_valid     = cif.corr_valid;

    // correction datapath, one register stage
    dcr_corr_apply u_apply
    (
        .clk    (clk),
        .arst_n (arst_n),
        .cif    (cif.datapath)
    );

    // ==========================================================
    // read mux; unmapped addresses read zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (reg_addr == ADDR_W'(`DCR_OFS_ATTEN_LP))
        begin
            nxt_rdata = {20'h00000, off_atten_lp_ff};
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_NOATTEN_LP))
        begin
            nxt_rdata = {20'h00000, off_noatten_lp_ff};
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_ATTEN_HS))
        begin
            nxt_rdata = {20'h00000, off_atten_hs_ff};
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_NOATTEN_HS))
        begin
            nxt_rdata = {20'h00000, off_noatten_hs_ff};
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_CAL_LOCK))
        begin
            nxt_rdata = lock_ff;
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_DAC_CTRL))
        begin
            nxt_rdata = {30'h0000_0000, ctrl_ff};
        end
        else if (reg_addr == ADDR_W'(`DCR_OFS_STATUS))
        begin
            nxt_rdata[`DCR_STAT_UNLOCK_BIT] = unlocked;
            nxt_rdata[`DCR_STAT_REJECT_BIT] = reject_ff;
            nxt_rdata[`DCR_STAT_ATTEN_BIT]  = atten_en;
            nxt_rdata[`DCR_STAT_HSMODE_BIT] = hs_mode;
            nxt_rdata[`DCR_STAT_SEL_LSB +: 2] = sel;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            rdata_ff <= nxt_rdata;
        end
        else
        begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule
